/* verilog/asc_alarm_bank.sv */
// alarm status and conversion select register bank with ahb-lite slave
// assumes one clock, synchronous reset, comparators and converter on the same clock
//
// Contract
// - flag sets only after N consecutive out-of-range checks
// - latched mode holds a flag until condition gone and status read
// - status read clears flags in latched mode only; persisting ones reassert at the next check
// - hardware and software reset clear all flags
// - unlatched mode drops a flag as soon as its condition ends
// - status register read-only, reset zero, bits 15,1,0 read zero
// - bits 14..11 flag analog inputs 0..3 and both pairs
// - bits 10 and 9 flag local temperature low and high when enabled
// - bits 8,7 and 6,5 flag remote sensor limits when enabled
// - bits 4 and 3 flag remote sensor open or short when enabled
// - bit 2 die over 150 C, 8 C hysteresis, zero if local off
// - channel select read/write, reset zero, bit 15 reads zero
// - select bits enable single inputs and the two pairs
// - selected inputs convert in order from bit 14 down
// - single-ended results stored straight binary per channel
// - pair results twos complement, stored in slots zero and two
// - hold-off control is alarm control bit 2, default zero
// - masked sources still set flags but keep alarm pin high
//
// Our own choice: the AHB-Lite register port.
module asc_alarm_bank #(
	parameter int FILTER_W = 4
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	input wire logic [11:0] out_of_range_i,
	input wire logic signed [9:0] die_temp_i,
	output asc_pkg::asc_conv_req_t conv_req_o,
	input wire logic conv_done_i,
	input wire logic [11:0] conv_data_i,
	output logic alarm_n_o
);
	import asc_pkg::*;

	typedef struct packed
	{
		logic [12:0] flags;
		logic [14:0] chsel;
		logic [12:0] unmask;
		logic flag_hold_off;
		logic [2:0] sensor_on;
		logic [FILTER_W-1:0] filter_n;
		logic die_hot;
		logic soft_clr;
		logic wr_valid;
		logic [9:0] wr_index;
		logic [31:0] hrdata;
		logic hreadyout;
		logic alarm_n;
		asc_conv_req_t conv_req;
		logic [ASC_SLOT_COUNT-1:0][12:0] results;
	} asc_bank_state_t;

	asc_bank_state_t s;
	asc_bank_state_t next_s;

	logic [12:0] src_on;
	logic [12:0] raw_cond;
	logic [12:0] persist;
	logic check;
	logic [14:0] select_eff;
	asc_conv_req_t seq_req;
	asc_res_wr_t seq_wr;
	logic accept;
	logic [9:0] rd_index;
	logic status_read;
	logic [15:0] rd_word;

	// ==========================================
	// source enables and raw conditions
	always_comb
	begin
		src_on = 13'h1ffe;
		if (!s.sensor_on[ASC_LOCAL_ON_BIT])
			src_on = src_on & ~ASC_LOCAL_SRC;
		if (!s.sensor_on[ASC_REMOTE_ONE_ON_BIT])
			src_on = src_on & ~ASC_REMOTE_ONE_SRC;
		if (!s.sensor_on[ASC_REMOTE_TWO_ON_BIT])
			src_on = src_on & ~ASC_REMOTE_TWO_SRC;
		src_on[ASC_DIE_SRC] = s.sensor_on[ASC_LOCAL_ON_BIT];
		// bits 14..3 come straight from the comparators, bit 2 from the die trip
		raw_cond = {out_of_range_i, s.die_hot} & src_on;
	end

	// ==========================================
	// pair bits only count when neither single of the pair is chosen
	always_comb
	begin
		select_eff = s.chsel;
		if (s.chsel[14] || s.chsel[13])
			select_eff[12] = 1'b0;
		if (s.chsel[11] || s.chsel[10])
			select_eff[9] = 1'b0;
	end

	asc_alarm_filter #(
		.WIDTH(ASC_SRC_COUNT),
		.CW(FILTER_W)
	) u_filter (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.clear_i(s.soft_clr),
		.check_i(check),
		.cond_i(raw_cond),
		.limit_i(s.filter_n),
		.persist_o(persist)
	);

	asc_conv_seq u_seq (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.select_i(select_eff),
		.conv_done_i(conv_done_i),
		.conv_data_i(conv_data_i),
		.req_o(seq_req),
		.wr_o(seq_wr),
		.cycle_done_o(check)
	);

	// ==========================================
	// next state
	always_comb
	begin
		next_s = s;
		next_s.soft_clr = 1'b0;
		next_s.wr_valid = 1'b0;
		next_s.hreadyout = 1'b1;
		next_s.conv_req = seq_req;
		rd_word = 16'h0000;

		// die trip with hysteresis, released well below the trip point
		if (!s.sensor_on[ASC_LOCAL_ON_BIT])
			next_s.die_hot = 1'b0;
		else if (die_temp_i >= ASC_DIE_TRIP_C)
			next_s.die_hot = 1'b1;
		else if (die_temp_i < ASC_DIE_RELEASE_C)
			next_s.die_hot = 1'b0;

		// result store
		if (seq_wr.valid && (seq_wr.slot < 4'(ASC_SLOT_COUNT)))
			next_s.results[seq_wr.slot] = {seq_wr.pair, seq_wr.data};

		// data phase of a write
		if (s.wr_valid)
		begin
			case (s.wr_index)
				ASC_CHSEL_INDEX: next_s.chsel = hwdata_i[14:0] & ASC_CHSEL_MASK[14:0];
				ASC_ALARM_CTRL_INDEX:
				begin
					next_s.unmask = hwdata_i[14:2];
					next_s.unmask[ASC_DIE_SRC] = 1'b0;
					next_s.flag_hold_off = hwdata_i[ASC_HOLD_OFF_BIT];
				end
				ASC_SENSOR_EN_INDEX: next_s.sensor_on = hwdata_i[2:0];
				ASC_FILTER_INDEX: next_s.filter_n = hwdata_i[FILTER_W-1:0];
				ASC_SOFT_RESET_INDEX: next_s.soft_clr = hwdata_i[0];
				// status is read-only, so writes there fall through
				default: next_s.soft_clr = 1'b0;
			endcase
		end

		// address phase
		accept = hsel_i && hready_i && htrans_i[1];
		rd_index = haddr_i[11:2];
		next_s.wr_valid = accept && hwrite_i && (hsize_i == 3'h2);
		next_s.wr_index = rd_index;
		status_read = accept && !hwrite_i && (rd_index == ASC_STATUS_INDEX);

		// read value taken from the state after any write of the data phase
		case (rd_index)
			ASC_STATUS_INDEX: rd_word = {1'b0, s.flags, 2'b00};
			ASC_CHSEL_INDEX: rd_word = {1'b0, next_s.chsel};
			ASC_ALARM_CTRL_INDEX: rd_word = {1'b0, next_s.unmask[12:1], next_s.flag_hold_off, 2'b00};
			ASC_SENSOR_EN_INDEX: rd_word = {13'h0000, next_s.sensor_on};
			ASC_FILTER_INDEX: rd_word = {{(16-FILTER_W){1'b0}}, next_s.filter_n};
			default:
			begin
				if ((rd_index >= ASC_RESULT_BASE_INDEX) &&
					(rd_index < ASC_RESULT_BASE_INDEX + 10'(ASC_SLOT_COUNT)))
					rd_word = {3'h0, next_s.results[4'(rd_index - ASC_RESULT_BASE_INDEX)]};
				else
					rd_word = 16'h0000;
			end
		endcase
		if (accept && !hwrite_i)
			next_s.hrdata = {16'h0000, rd_word};

		// ==========================================
		// flag update
		for (int i = 0; i < ASC_SRC_COUNT; i++)
		begin
			if (s.soft_clr)
				next_s.flags[i] = 1'b0;
			else if (!src_on[i])
				next_s.flags[i] = 1'b0;
			else if (s.flag_hold_off)
				next_s.flags[i] = persist[i];
			else if (check && persist[i])
				next_s.flags[i] = 1'b1;
			else if (status_read)
				next_s.flags[i] = 1'b0;
		end

		// mask gates only the pin, never the flag
		next_s.alarm_n = ~|(next_s.flags & next_s.unmask);
	end

	// ==========================================
	// state register
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			s <= '0;
			s.flags <= ASC_STATUS_RESET[14:2];
			s.chsel <= ASC_CHSEL_RESET[14:0];
			s.unmask <= ASC_UNMASK_RESET;
			s.flag_hold_off <= ASC_ALARM_CTRL_RESET[ASC_HOLD_OFF_BIT];
			s.sensor_on <= ASC_SENSOR_EN_RESET;
			s.filter_n <= ASC_FILTER_RESET[FILTER_W-1:0];
			s.hreadyout <= 1'b1;
			s.alarm_n <= 1'b1;
		end
		else
			s <= next_s;
	end

	assign hrdata_o = s.hrdata;
	assign hreadyout_o = s.hreadyout;
	assign hresp_o = 1'b0;
	assign conv_req_o = s.conv_req;
	assign alarm_n_o = s.alarm_n;

endmodule

/* verilog/asc_pkg.sv */
// constants, carrier types and decode helpers for the alarm status and channel select bank
// assumes a 32-bit ahb-lite bus with word registers at four times their index
package asc_pkg;

	// ==========================================
	// register indices (byte address = index * 4)
	localparam logic [9:0] ASC_STATUS_INDEX = 10'h04f;
	localparam logic [9:0] ASC_CHSEL_INDEX = 10'h050;
	localparam logic [9:0] ASC_ALARM_CTRL_INDEX = 10'h040;
	localparam logic [9:0] ASC_SENSOR_EN_INDEX = 10'h041;
	localparam logic [9:0] ASC_FILTER_INDEX = 10'h042;
	localparam logic [9:0] ASC_SOFT_RESET_INDEX = 10'h043;
	localparam logic [9:0] ASC_RESULT_BASE_INDEX = 10'h060;

	// ==========================================
	// reset values and writable masks
	localparam logic [15:0] ASC_STATUS_RESET = 16'h0000;
	localparam logic [15:0] ASC_CHSEL_RESET = 16'h0000;
	localparam logic [15:0] ASC_ALARM_CTRL_RESET = 16'h0000;
	localparam logic [2:0] ASC_SENSOR_EN_RESET = 3'h0;
	localparam logic [3:0] ASC_FILTER_RESET = 4'h4;
	localparam logic [15:0] ASC_CHSEL_MASK = 16'h7fff;
	localparam logic [12:0] ASC_UNMASK_RESET = 13'h0000;

	// ==========================================
	// field positions
	localparam int ASC_SRC_COUNT = 13;
	localparam int ASC_SRC_LSB = 2;
	localparam int ASC_HOLD_OFF_BIT = 2;
	localparam int ASC_SEQ_BITS = 15;
	localparam int ASC_SLOT_COUNT = 13;
	localparam int ASC_LOCAL_ON_BIT = 0;
	localparam int ASC_REMOTE_ONE_ON_BIT = 1;
	localparam int ASC_REMOTE_TWO_ON_BIT = 2;
	// sources by status bit minus two
	localparam logic [12:0] ASC_LOCAL_SRC = 13'h0181;
	localparam logic [12:0] ASC_REMOTE_ONE_SRC = 13'h0064;
	localparam logic [12:0] ASC_REMOTE_TWO_SRC = 13'h001a;
	localparam int ASC_DIE_SRC = 0;

	// ==========================================
	// die temperature trip, whole degrees celsius
	localparam logic signed [9:0] ASC_DIE_TRIP_C = 10'sh096;
	localparam logic signed [9:0] ASC_DIE_HYST_C = 10'sh008;
	localparam logic signed [9:0] ASC_DIE_RELEASE_C = ASC_DIE_TRIP_C - ASC_DIE_HYST_C;

	// ==========================================
	// carriers
	typedef struct packed
	{
		logic start;
		logic [3:0] slot;
		logic pair;
	} asc_conv_req_t;

	typedef struct packed
	{
		logic valid;
		logic [3:0] slot;
		logic [11:0] data;
		logic pair;
	} asc_res_wr_t;

	// ==========================================
	// select bit to data register slot
	function automatic logic [3:0] asc_bit_slot(input logic [3:0] b);
		logic [3:0] slot;
		slot = 4'h0;
		case (b)
			4'he: slot = 4'h0;
			4'hd: slot = 4'h1;
			4'hc: slot = 4'h0;
			4'hb: slot = 4'h2;
			4'ha: slot = 4'h3;
			4'h9: slot = 4'h2;
			default: slot = 4'hc - b;
		endcase
		return slot;
	endfunction

	function automatic logic asc_bit_is_pair(input logic [3:0] b);
		return (b == 4'hc) || (b == 4'h9);
	endfunction

endpackage

/* verilog/asc_alarm_filter.sv */
// per-source consecutive out-of-range filter
// assumes check_i is a one-cycle pulse per conversion cycle on the same clock
module asc_alarm_filter #(
	parameter int WIDTH = 13,
	parameter int CW = 4
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic clear_i,
	input wire logic check_i,
	input wire logic [WIDTH-1:0] cond_i,
	input wire logic [CW-1:0] limit_i,
	output logic [WIDTH-1:0] persist_o
);
	import asc_pkg::*;

	typedef struct packed
	{
		logic [WIDTH-1:0][CW-1:0] cnt;
		logic [WIDTH-1:0] persist;
	} asc_filt_state_t;

	asc_filt_state_t s;
	asc_filt_state_t next_s;
	logic [CW-1:0] lim;
	logic [CW:0] bumped;

	// ==========================================
	// counting
	always_comb
	begin
		next_s = s;
		lim = (limit_i == '0) ? {{(CW-1){1'b0}}, 1'b1} : limit_i;
		bumped = '0;
		for (int i = 0; i < WIDTH; i++)
		begin
			bumped = {1'b0, s.cnt[i]} + {{CW{1'b0}}, 1'b1};
			if (clear_i)
			begin
				next_s.cnt[i] = '0;
				next_s.persist[i] = 1'b0;
			end
			else if (check_i)
			begin
				if (cond_i[i])
				begin
					// saturate so a long fault never wraps back to clear
					if (!(&s.cnt[i]))
						next_s.cnt[i] = bumped[CW-1:0];
					next_s.persist[i] = (bumped >= {1'b0, lim});
				end
				else
				begin
					next_s.cnt[i] = '0;
					next_s.persist[i] = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			s <= '0;
		else
			s <= next_s;
	end

	assign persist_o = s.persist;

endmodule

/* verilog/asc_conv_seq.sv */
// conversion sequencer walking the select bits from the top down
// assumes the converter answers each start with exactly one done pulse
module asc_conv_seq (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [14:0] select_i,
	input wire logic conv_done_i,
	input wire logic [11:0] conv_data_i,
	output asc_pkg::asc_conv_req_t req_o,
	output asc_pkg::asc_res_wr_t wr_o,
	output logic cycle_done_o
);
	import asc_pkg::*;

	typedef enum logic [0:0] {SEQ_PICK, SEQ_WAIT} asc_seq_mode_t;

	typedef struct packed
	{
		asc_seq_mode_t mode;
		logic [14:0] remain;
		asc_conv_req_t req;
		asc_res_wr_t wr;
		logic cycle_done;
	} asc_seq_state_t;

	asc_seq_state_t s;
	asc_seq_state_t next_s;
	logic [3:0] top;

	// ==========================================
	// walk
	always_comb
	begin
		next_s = s;
		next_s.req.start = 1'b0;
		next_s.wr.valid = 1'b0;
		next_s.cycle_done = 1'b0;
		top = 4'h0;
		for (int i = 0; i < ASC_SEQ_BITS; i++)
		begin
			if (s.remain[i])
				top = i[3:0];
		end
		case (s.mode)
			SEQ_PICK:
			begin
				if (s.remain == '0)
				begin
					next_s.remain = select_i;
					next_s.cycle_done = 1'b1;
				end
				else
				begin
					// highest set bit first, so order follows bit 14 down to 0
					next_s.remain[top] = 1'b0;
					next_s.req.start = 1'b1;
					next_s.req.slot = asc_bit_slot(top);
					next_s.req.pair = asc_bit_is_pair(top);
					next_s.mode = SEQ_WAIT;
				end
			end
			SEQ_WAIT:
			begin
				if (conv_done_i)
				begin
					next_s.wr.valid = 1'b1;
					next_s.wr.slot = s.req.slot;
					next_s.wr.data = conv_data_i;
					next_s.wr.pair = s.req.pair;
					next_s.mode = SEQ_PICK;
				end
			end
			default: next_s.mode = SEQ_PICK;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			s <= '0;
		else
			s <= next_s;
	end

	assign req_o = s.req;
	assign wr_o = s.wr;
	assign cycle_done_o = s.cycle_done;

endmodule

/* tb/asc_conv_model.sv */
// converter stand-in on the conversion link
// assumes one start pulse at a time; answers fast and slow in turn
module asc_conv_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire asc_pkg::asc_conv_req_t req_i,
	output logic done_o,
	output logic [11:0] data_o
);
	timeunit 1ns;
	timeprecision 1ps;
	import asc_pkg::*;
	logic busy = 1'b0;
	logic slow = 1'b0;
	logic [2:0] cnt = 3'h0;
	logic [11:0] word = 12'h0;
	initial
	begin
		done_o = 1'b0;
		data_o = 12'h0;
	end
	// ========
	// answer
	// data lines toggle outside done so a late capture shows up
	always @(posedge clk_i)
	begin
		done_o <= 1'b0;
		data_o <= ~data_o;
		if (rst_i)
			busy <= 1'b0;
		else if (req_i.start)
		begin
			busy <= 1'b1;
			cnt <= slow ? 3'h4 : 3'h0;
			slow <= ~slow;
			word <= {req_i.pair, 7'h0, req_i.slot};
		end
		else if (busy && cnt == 3'h0)
		begin
			busy <= 1'b0;
			done_o <= 1'b1;
			data_o <= word;
		end
		else if (busy)
			cnt <= cnt - 3'h1;
	end
endmodule

/* tb/asc_alarm_bank_sva.sv */
// port assertions for the alarm bank
// assumes a bind onto asc_alarm_bank
module asc_alarm_bank_sva #(
	parameter int FILTER_W = 4
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic hready_i,
	input wire logic [31:0] hrdata_o,
	input wire logic hreadyout_o,
	input wire logic hresp_o,
	input wire asc_pkg::asc_conv_req_t conv_req_o,
	input wire logic conv_done_i,
	input wire logic alarm_n_o
);
	import asc_pkg::*;
	wire logic rd_ph = hsel_i && hready_i && htrans_i[1] && !hwrite_i;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// ========
	// bus
	chk_ready_high: assert property (hreadyout_o)
		else $error("hreadyout low");
	chk_resp_okay: assert property (!hresp_o)
		else $error("hresp not okay");
	chk_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !hrdata_o && alarm_n_o && !conv_req_o.start)
		else $error("outputs not quiet after reset");
	chk_status_rsv: assert property (rd_ph && haddr_i[11:2] == ASC_STATUS_INDEX |=> !hrdata_o[31:15] && !hrdata_o[1:0])
		else $error("status reserved bits set");
	chk_select_rsv: assert property (rd_ph && haddr_i[11:2] == ASC_CHSEL_INDEX |=> !hrdata_o[31:15])
		else $error("select reserved bits set");
	// ========
	// conversion link
	chk_start_pulse: assert property (conv_req_o.start |=> !conv_req_o.start)
		else $error("start longer than one cycle");
	chk_done_gap: assert property (conv_done_i |=> !conv_req_o.start)
		else $error("start right after done");
	chk_pair_slot: assert property (conv_req_o.start && conv_req_o.pair |-> conv_req_o.slot inside {4'h0, 4'h2})
		else $error("pair result slot wrong");
	chk_slot_hold: assert property (!conv_req_o.start |-> $stable({conv_req_o.slot, conv_req_o.pair}))
		else $error("slot moved without start");
endmodule
bind asc_alarm_bank asc_alarm_bank_sva #(.FILTER_W(FILTER_W)) chk_u (.clk_i(clk_i), .rst_i(rst_i),
	.hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i),
	.hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .conv_req_o(conv_req_o),
	.conv_done_i(conv_done_i), .alarm_n_o(alarm_n_o));

/* tb/tb_alarm_status_and_adc_channel_select.sv */
// self-checking bench: ahb-lite master tasks and one task per scenario
// assumes asc_conv_model answers the conversion link
`define CHK(n, e, g) comparisons++; if ((g) !== (e)) begin mismatches++; $display("mismatch %s exp %h got %h", n, e, g); end
module tb_alarm_status_and_adc_channel_select;
	timeunit 1ns;
	timeprecision 1ps;
	import asc_pkg::*;
	localparam logic [31:0] ST = {20'h0, ASC_STATUS_INDEX, 2'h0};
	localparam logic [31:0] CS = {20'h0, ASC_CHSEL_INDEX, 2'h0};
	localparam logic [31:0] AC = {20'h0, ASC_ALARM_CTRL_INDEX, 2'h0};
	localparam logic [31:0] SN = {20'h0, ASC_SENSOR_EN_INDEX, 2'h0};
	localparam logic [31:0] SR = {20'h0, ASC_SOFT_RESET_INDEX, 2'h0};
	localparam logic [31:0] RB = {20'h0, ASC_RESULT_BASE_INDEX, 2'h0};
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] rd;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [11:0] oor = 12'h0;
	logic signed [9:0] die = 10'sh000;
	logic [31:0] hrdata;
	logic hready;
	logic hresp;
	asc_conv_req_t req;
	logic done;
	logic [11:0] cdata;
	logic alarm_n;
	int mismatches = 0;
	int comparisons = 0;
	logic [4:0] q[$];
	always #10 clk_i = ~clk_i;
	asc_alarm_bank dut_u (.clk_i(clk_i), .rst_i(rst_i), .hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htrans),
		.hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
		.hreadyout_o(hready), .hresp_o(hresp), .out_of_range_i(oor), .die_temp_i(die), .conv_req_o(req),
		.conv_done_i(done), .conv_data_i(cdata), .alarm_n_o(alarm_n));
	asc_conv_model conv_u (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .done_o(done), .data_o(cdata));
	always @(posedge clk_i)
		if (req.start === 1'b1)
			q.push_back({req.slot, req.pair});
	// ========
	// bus tasks
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge clk_i); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk_i); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	task automatic rc(input string n, input logic [31:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		`CHK(n, e, rd)
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk_i);
	endtask
	// ========
	// scenarios
	task automatic t_regs;
		rc("status", ST, 32'h0);
		rc("select", CS, 32'h0);
		rc("control", AC, 32'h0);
		bus(1'b1, ST, 32'hffff);
		rc("status", ST, 32'h0);
		bus(1'b1, CS, 32'h8000);
		rc("select", CS, 32'h0);
		rc("unmapped", 32'h1f0, 32'h0);
	endtask
	task automatic t_latch;
		oor <= 12'h800;
		cyc(3);
		oor <= 12'h0;
		cyc(8);
		rc("status", ST, 32'h0);
		oor <= 12'h800;
		cyc(10);
		`CHK("alarm_n", 1'b1, alarm_n)
		bus(1'b1, AC, 32'h4000);
		cyc(3);
		`CHK("alarm_n", 1'b0, alarm_n)
		rc("status", ST, 32'h4000);
		rc("status", ST, 32'h4000);
		cyc(5);
		oor <= 12'h0;
		cyc(8);
		rc("status", ST, 32'h4000);
		rc("status", ST, 32'h0);
		oor <= 12'h800;
		cyc(10);
		oor <= 12'h0;
		bus(1'b1, SR, 32'h1);
		cyc(3);
		rc("status", ST, 32'h0);
		bus(1'b1, AC, 32'h0);
	endtask
	task automatic t_unlatch;
		bus(1'b1, AC, 32'h4);
		oor <= 12'h400;
		cyc(10);
		rc("status", ST, 32'h2000);
		cyc(10);
		oor <= 12'h0;
		cyc(4);
		rc("status", ST, 32'h0);
	endtask
	task automatic t_sense;
		oor <= 12'h0ff;
		die <= 10'sh096;
		cyc(10);
		rc("status", ST, 32'h0);
		bus(1'b1, SN, 32'h7);
		cyc(10);
		rc("status", ST, 32'h7fc);
		die <= 10'sh08f;
		cyc(10);
		rc("status", ST, 32'h7fc);
		die <= 10'sh08d;
		cyc(10);
		rc("status", ST, 32'h7f8);
		die <= 10'sh095;
		cyc(10);
		rc("status", ST, 32'h7f8);
		bus(1'b1, SN, 32'h0);
		cyc(3);
		rc("status", ST, 32'h0);
		oor <= 12'h0;
		die <= 10'sh000;
		bus(1'b1, AC, 32'h0);
	endtask
	task automatic t_seq;
		q.delete();
		bus(1'b1, CS, 32'h1201);
		rc("select", CS, 32'h1201);
		cyc(100);
		`CHK("first", 5'h01, q[0])
		`CHK("second", 5'h05, q[1])
		`CHK("third", 5'h18, q[2])
		// read the pair slots before the single-ended walk overwrites slot zero
		rc("slot0", RB, 32'h1800);
		rc("slot2", RB + 32'h8, 32'h1802);
		rc("slot12", RB + 32'h30, 32'h000c);
		bus(1'b1, CS, 32'h7000);
		cyc(40);
		q.delete();
		cyc(60);
		`CHK("single", 5'h00, q[0] & 5'h1d)
		bus(1'b1, CS, 32'h0);
		cyc(40);
		rc("slot0", RB, 32'h0000);
		rc("slot1", RB + 32'h4, 32'h0001);
	endtask
	// ========
	// run
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial
	begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_regs();
		t_latch();
		t_unlatch();
		t_sense();
		t_seq();
		test_done();
	end
	// hang guard, far beyond the few hundred cycles the run needs
	initial
	begin
		repeat (20000) @(posedge clk_i);
		mismatches++;
		test_done();
	end
endmodule
